// file: rtl/timer_unit_pkg.sv
`default_nettype none
package timer_unit_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE_SELECT = 8'h89;
	localparam logic [7:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
	localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h8b;
	localparam logic [7:0] IDX_TIMER0_COUNT_HIGH = 8'h8c;
	localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
	localparam logic [7:0] IDX_CC_ENABLE = 8'hc1;
	localparam logic [7:0] IDX_CC1_LOW = 8'hc2;
	localparam logic [7:0] IDX_CC1_HIGH = 8'hc3;
	localparam logic [7:0] IDX_CC2_LOW = 8'hc4;
	localparam logic [7:0] IDX_CC2_HIGH = 8'hc5;
	localparam logic [7:0] IDX_CC3_LOW = 8'hc6;
	localparam logic [7:0] IDX_CC3_HIGH = 8'hc7;
	localparam logic [7:0] IDX_SECOND_TIMER_CONTROL = 8'hc8;
	localparam logic [7:0] IDX_RELOAD_VALUE_LOW = 8'hca;
	localparam logic [7:0] IDX_RELOAD_VALUE_HIGH = 8'hcb;
	localparam logic [7:0] IDX_SECOND_TIMER_LOW_BYTE = 8'hcc;
	localparam logic [7:0] IDX_SECOND_TIMER_HIGH_BYTE = 8'hcd;
	localparam logic [7:0] IDX_COMPARE_LEVEL = 8'hce;
	localparam logic [7:0] IDX_SECOND_TIMER_STATUS = 8'hcf;
	localparam logic [7:0] REG_RESET = 8'h00;
	// timer_control fields
	localparam int TF1_BIT = 7;
	localparam int TR1_BIT = 6;
	localparam int TF0_BIT = 5;
	localparam int TR0_BIT = 4;
	// timer_mode_select fields, one nibble per timer
	localparam int T1_NIBBLE = 4;
	localparam int GATE_BIT = 3;
	localparam int CT_BIT = 2;
	localparam logic [1:0] MODE_PRESCALE = 2'h0;
	localparam logic [1:0] MODE_FULL = 2'h1;
	localparam logic [1:0] MODE_RELOAD8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [4:0] PRESCALE_MAX = 5'h1f;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [15:0] WORD_MAX = 16'hffff;
	// Second timer control and status fields
	localparam logic [1:0] T2_STOP = 2'h0;
	localparam logic [1:0] T2_TIMER = 2'h1;
	localparam logic [1:0] T2_COUNTER = 2'h2;
	localparam logic [1:0] T2_GATED = 2'h3;
	localparam int T2_PRESCALE_BIT = 2;
	localparam int T2_RELOAD_MODE_BIT = 3;
	localparam int T2_RELOAD_EN_BIT = 4;
	localparam int T2_CAPTURE_MODE_BIT = 5;
	localparam int T2_COMPARE_MODE_BIT = 6;
	localparam int ST_OVF_BIT = 0;
	localparam int ST_TRIG_BIT = 1;
	localparam int ST_MATCH_LSB = 2;
	localparam logic [1:0] CC_CAPTURE = 2'h1;
	localparam logic [1:0] CC_COMPARE = 2'h2;
	// Machine cycle divider
	localparam logic [3:0] OSC_DIVIDE = 4'hc;
	// Synchronised pin positions
	localparam int PIN_COUNT0 = 0;
	localparam int PIN_COUNT1 = 1;
	localparam int PIN_GATE_A = 2;
	localparam int PIN_GATE_B = 3;
	localparam int PIN_T2 = 4;
	localparam int PIN_TRIG = 5;
	localparam int PIN_CC_LSB = 6;
	localparam int NUM_PINS = 10;
	typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_WRITE = 3'b010, BUS_READ = 3'b100} bus_state_t;
endpackage : timer_unit_pkg
`default_nettype wire

// file: rtl/triple_timer_counter_unit.sv
// What this block does
// - Three independent timer/counters, each holding a 16-bit count.
// - Timer operation counts once per machine cycle, oscillator divided by twelve.
// - Counter operation counts external edges at most one per 24 oscillator clocks.
// - Mode 0: 8-bit counter behind a divide-by-32 prescaler, timers 0 and 1.
// - Mode 1: full 16-bit counter, timers 0 and 1.
// - Mode 2: 8-bit counter reloading from the high byte on overflow.
// - Mode 3: timer 0 splits into an 8-bit timer/counter and an 8-bit timer.
// - Timer 1 in mode 3 stops and holds its count.
// - Gate inputs a and b may enable counting of timers 0 and 1.
// - Timer 2 is 16-bit with selectable divide-by-2 prescaler and gate.
// - Timer 2 has four 16-bit capture/compare registers, each with its own pin.
// - The reload register loads timer 2 on a reload event.
// - Reload mode 0 reloads timer 2 on its overflow.
// - Reload mode 1 reloads on a trigger pin falling edge and flags a request.
// - A capture copies the current 16-bit timer 2 value into the register.
// - Capture mode 0 captures on a rising edge of the channel pin.
// - Capture mode 1 captures on a software write to the low byte.
// - Compare mode matches register against timer 2, drives the pin, flags a request.
// - Compare mode 0: pin goes high on match, low on timer 2 overflow.
// - Compare mode 1: software picks the match level; overflow leaves the pin.
//
// Our own choice: the AHB-Lite interface to the registers.
`default_nettype none
module triple_timer_counter_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic timer0_count_pin,
	input wire logic timer1_count_pin,
	input wire logic gate_input_a,
	input wire logic gate_input_b,
	input wire logic second_timer_count_pin,
	input wire logic reload_trigger_pin,
	input wire logic [3:0] capture_compare_pin_in,
	output logic [3:0] capture_compare_pin_out,
	output logic [3:0] capture_compare_pin_oe
);
	typedef struct packed {
		timer_unit_pkg::bus_state_t bus;
		logic [7:0] idx;
		logic hready_o;
		logic [31:0] rdata;
		logic hresp_o;
		logic [3:0] tick_cnt;
		logic [9:0] sync1;
		logic [9:0] sync2;
		logic [9:0] smp;
		logic [7:0] timer_control;
		logic [7:0] timer_mode_select;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [15:0] t2;
		logic pre2;
		logic [7:0] t2ctl;
		logic [7:0] t2stat;
		logic [7:0] ccen;
		logic [3:0][15:0] cc;
		logic [3:0] cmp_level;
		logic [3:0] cmp_out;
		logic [3:0] cc_oe;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic tick;
	logic [9:0] fall;
	logic [9:0] rise;
	logic ev0;
	logic ev1;
	logic ev2;
	logic ovf2;
	logic wr_now;

	// One 8-bit/16-bit step of timer 0 or 1; returns {overflow, high, low}
	function automatic logic [16:0] step01(input logic [1:0] mode, input logic [7:0] tl, input logic [7:0] th);
		logic [16:0] r;
		r = {1'b0, th, tl};
		case (mode)
			timer_unit_pkg::MODE_PRESCALE: begin
				if (tl[4:0] == timer_unit_pkg::PRESCALE_MAX) begin
					r = {th == timer_unit_pkg::BYTE_MAX, th + 8'h01, tl[7:5], 5'h00};
				end else begin
					r = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
				end
			end
			timer_unit_pkg::MODE_FULL: begin
				r = {({th, tl} == timer_unit_pkg::WORD_MAX), {th, tl} + 16'h0001};
			end
			timer_unit_pkg::MODE_RELOAD8: begin
				if (tl == timer_unit_pkg::BYTE_MAX) begin
					r = {1'b1, th, th};
				end else begin
					r = {1'b0, th, tl + 8'h01};
				end
			end
			default: begin
				r = {1'b0, th, tl};
			end
		endcase
		return r;
	endfunction : step01

	// Run enable with optional gate pin
	function automatic logic run_gate(input logic tr, input logic gate, input logic pin);
		return tr & (~gate | pin);
	endfunction : run_gate

	// Capture/compare register decode: {hit, high byte, channel}
	function automatic logic [3:0] cc_decode(input logic [7:0] idx);
		case (idx)
			timer_unit_pkg::IDX_RELOAD_VALUE_LOW: return 4'b1000;
			timer_unit_pkg::IDX_RELOAD_VALUE_HIGH: return 4'b1100;
			timer_unit_pkg::IDX_CC1_LOW: return 4'b1001;
			timer_unit_pkg::IDX_CC1_HIGH: return 4'b1101;
			timer_unit_pkg::IDX_CC2_LOW: return 4'b1010;
			timer_unit_pkg::IDX_CC2_HIGH: return 4'b1110;
			timer_unit_pkg::IDX_CC3_LOW: return 4'b1011;
			timer_unit_pkg::IDX_CC3_HIGH: return 4'b1111;
			default: return 4'b0000;
		endcase
	endfunction : cc_decode

	// Machine cycle strobe and pin events, both only on the strobe
	assign tick = (s_reg.tick_cnt == timer_unit_pkg::OSC_DIVIDE - 4'h1);
	assign fall = tick ? (s_reg.smp & ~s_reg.sync2) : 10'h000;
	assign rise = tick ? (~s_reg.smp & s_reg.sync2) : 10'h000;
	assign wr_now = (s_reg.bus == timer_unit_pkg::BUS_WRITE);
	// Count events; external edges are sampled once per machine cycle, so at most one per two
	assign ev0 = run_gate(s_reg.timer_control[timer_unit_pkg::TR0_BIT], s_reg.timer_mode_select[timer_unit_pkg::GATE_BIT],
		s_reg.sync2[timer_unit_pkg::PIN_GATE_A]) &
		(s_reg.timer_mode_select[timer_unit_pkg::CT_BIT] ? fall[timer_unit_pkg::PIN_COUNT0] : tick);
	assign ev1 = run_gate(s_reg.timer_control[timer_unit_pkg::TR1_BIT], s_reg.timer_mode_select[timer_unit_pkg::T1_NIBBLE + 3],
		s_reg.sync2[timer_unit_pkg::PIN_GATE_B]) &
		(s_reg.timer_mode_select[timer_unit_pkg::T1_NIBBLE + 2] ? fall[timer_unit_pkg::PIN_COUNT1] : tick);
	// Timer 2 source select with optional halving; the counter input bypasses the prescaler
	always_comb begin
		logic base;
		logic pre_on;
		base = 1'b0;
		case (s_reg.t2ctl[1:0])
			timer_unit_pkg::T2_TIMER: base = tick;
			timer_unit_pkg::T2_COUNTER: base = fall[timer_unit_pkg::PIN_T2];
			timer_unit_pkg::T2_GATED: base = tick & s_reg.sync2[timer_unit_pkg::PIN_T2];
			default: base = 1'b0;
		endcase
		pre_on = s_reg.t2ctl[timer_unit_pkg::T2_PRESCALE_BIT] & (s_reg.t2ctl[1:0] != timer_unit_pkg::T2_COUNTER);
		ev2 = base & (~pre_on | s_reg.pre2);
	end
	assign ovf2 = ev2 & (s_reg.t2 == timer_unit_pkg::WORD_MAX);

	// Whole next state
	always_comb begin
		logic [16:0] r0;
		logic [16:0] r1;
		logic set_tf0;
		logic set_tf1;
		logic set_trig;
		logic [3:0] match;
		logic [3:0] dec;
		logic [7:0] wd;
		logic [31:0] rd;
		logic [1:0] chm;
		s_next = s_reg;
		r0 = 17'h0_0000;
		r1 = 17'h0_0000;
		set_tf0 = 1'b0;
		set_tf1 = 1'b0;
		set_trig = 1'b0;
		match = 4'h0;
		dec = 4'h0;
		wd = hwdata[7:0];
		rd = 32'h0000_0000;
		chm = 2'h0;
		// Two-stage synchronisers, then per-cycle sample for edge detection
		s_next.sync1 = {capture_compare_pin_in, reload_trigger_pin, second_timer_count_pin,
			gate_input_b, gate_input_a, timer1_count_pin, timer0_count_pin};
		s_next.sync2 = s_reg.sync1;
		s_next.tick_cnt = tick ? 4'h0 : s_reg.tick_cnt + 4'h1;
		if (tick) begin
			s_next.smp = s_reg.sync2;
		end
		// Timer 0, normal or split
		if (s_reg.timer_mode_select[1:0] != timer_unit_pkg::MODE_SPLIT) begin
			r0 = step01(s_reg.timer_mode_select[1:0], s_reg.tl0, s_reg.th0);
			if (ev0) begin
				{s_next.th0, s_next.tl0} = r0[15:0];
				set_tf0 = r0[16];
			end
		end else begin
			if (ev0) begin
				s_next.tl0 = s_reg.tl0 + 8'h01;
				set_tf0 = (s_reg.tl0 == timer_unit_pkg::BYTE_MAX);
			end
			if (s_reg.timer_control[timer_unit_pkg::TR1_BIT] & tick) begin
				s_next.th0 = s_reg.th0 + 8'h01;
				set_tf1 = (s_reg.th0 == timer_unit_pkg::BYTE_MAX);
			end
		end
		// Timer 1; its flag belongs to the upper half of timer 0 while that is split
		r1 = step01(s_reg.timer_mode_select[5:4], s_reg.tl1, s_reg.th1);
		if (ev1) begin
			{s_next.th1, s_next.tl1} = r1[15:0];
			if (s_reg.timer_mode_select[1:0] != timer_unit_pkg::MODE_SPLIT) begin
				set_tf1 = r1[16];
			end
		end
		// Timer 2 count and reload
		if (ev2 & (s_reg.t2ctl[1:0] != timer_unit_pkg::T2_COUNTER)) begin
			s_next.pre2 = ~s_reg.pre2;
		end
		if (ev2 | (s_reg.t2ctl[timer_unit_pkg::T2_PRESCALE_BIT] & ~s_reg.pre2 & tick)) begin
			s_next.pre2 = ~s_reg.pre2;
		end
		if (ev2) begin
			s_next.t2 = s_reg.t2 + 16'h0001;
		end
		if (ovf2 & s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_EN_BIT] & ~s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_MODE_BIT]) begin
			s_next.t2 = s_reg.cc[0];
		end
		if (fall[timer_unit_pkg::PIN_TRIG] & s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_EN_BIT] &
			s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_MODE_BIT]) begin
			s_next.t2 = s_reg.cc[0];
			set_trig = 1'b1;
		end
		// Compare and capture channels
		for (int i = 0; i < 4; i++) begin
			chm = s_reg.ccen[2 * i +: 2];
			if (chm == timer_unit_pkg::CC_COMPARE) begin
				if (ovf2 & ~s_reg.t2ctl[timer_unit_pkg::T2_COMPARE_MODE_BIT]) begin
					s_next.cmp_out[i] = 1'b0;
				end
				if (ev2 & (s_next.t2 == s_reg.cc[i])) begin
					match[i] = 1'b1;
					s_next.cmp_out[i] = s_reg.t2ctl[timer_unit_pkg::T2_COMPARE_MODE_BIT] ?
						s_reg.cmp_level[i] : 1'b1;
				end
			end
			if ((chm == timer_unit_pkg::CC_CAPTURE) & ~s_reg.t2ctl[timer_unit_pkg::T2_CAPTURE_MODE_BIT] &
				rise[timer_unit_pkg::PIN_CC_LSB + i]) begin
				s_next.cc[i] = s_reg.t2;
			end
		end
		// Bus: write data phase, read wait cycle, then address phase capture
		case (s_reg.bus)
			timer_unit_pkg::BUS_WRITE: begin
				dec = cc_decode(s_reg.idx);
				case (s_reg.idx)
					timer_unit_pkg::IDX_TIMER_CONTROL: s_next.timer_control = wd;
					timer_unit_pkg::IDX_TIMER_MODE_SELECT: s_next.timer_mode_select = wd;
					timer_unit_pkg::IDX_TIMER0_COUNT_LOW: s_next.tl0 = wd;
					timer_unit_pkg::IDX_TIMER1_COUNT_LOW: s_next.tl1 = wd;
					timer_unit_pkg::IDX_TIMER0_COUNT_HIGH: s_next.th0 = wd;
					timer_unit_pkg::IDX_TIMER1_COUNT_HIGH: s_next.th1 = wd;
					timer_unit_pkg::IDX_CC_ENABLE: s_next.ccen = wd;
					timer_unit_pkg::IDX_SECOND_TIMER_CONTROL: s_next.t2ctl = wd;
					timer_unit_pkg::IDX_SECOND_TIMER_STATUS: s_next.t2stat = wd;
					timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE: s_next.t2[7:0] = wd;
					timer_unit_pkg::IDX_SECOND_TIMER_HIGH_BYTE: s_next.t2[15:8] = wd;
					timer_unit_pkg::IDX_COMPARE_LEVEL: s_next.cmp_level = wd[3:0];
					default: begin
						if (dec[3] & dec[2]) begin
							s_next.cc[dec[1:0]][15:8] = wd;
						end else if (dec[3] & s_reg.t2ctl[timer_unit_pkg::T2_CAPTURE_MODE_BIT] &
							(s_reg.ccen[2 * dec[1:0] +: 2] == timer_unit_pkg::CC_CAPTURE)) begin
							s_next.cc[dec[1:0]] = s_reg.t2;
						end else if (dec[3]) begin
							s_next.cc[dec[1:0]][7:0] = wd;
						end
					end
				endcase
			end
			timer_unit_pkg::BUS_READ: begin
				dec = cc_decode(s_reg.idx);
				case (s_reg.idx)
					timer_unit_pkg::IDX_TIMER_CONTROL: rd[7:0] = s_reg.timer_control;
					timer_unit_pkg::IDX_TIMER_MODE_SELECT: rd[7:0] = s_reg.timer_mode_select;
					timer_unit_pkg::IDX_TIMER0_COUNT_LOW: rd[7:0] = s_reg.tl0;
					timer_unit_pkg::IDX_TIMER1_COUNT_LOW: rd[7:0] = s_reg.tl1;
					timer_unit_pkg::IDX_TIMER0_COUNT_HIGH: rd[7:0] = s_reg.th0;
					timer_unit_pkg::IDX_TIMER1_COUNT_HIGH: rd[7:0] = s_reg.th1;
					timer_unit_pkg::IDX_CC_ENABLE: rd[7:0] = s_reg.ccen;
					timer_unit_pkg::IDX_SECOND_TIMER_CONTROL: rd[7:0] = s_reg.t2ctl;
					timer_unit_pkg::IDX_SECOND_TIMER_STATUS: rd[7:0] = s_reg.t2stat;
					timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE: rd[7:0] = s_reg.t2[7:0];
					timer_unit_pkg::IDX_SECOND_TIMER_HIGH_BYTE: rd[7:0] = s_reg.t2[15:8];
					timer_unit_pkg::IDX_COMPARE_LEVEL: rd[3:0] = s_reg.cmp_level;
					default: begin
						if (dec[3]) begin
							rd[7:0] = dec[2] ? s_reg.cc[dec[1:0]][15:8] : s_reg.cc[dec[1:0]][7:0];
						end
					end
				endcase
				s_next.rdata = rd;
			end
			default: begin
			end
		endcase
		if (s_reg.bus == timer_unit_pkg::BUS_READ) begin
			s_next.bus = timer_unit_pkg::BUS_IDLE;
			s_next.hready_o = 1'b1;
		end else if (hsel & htrans[1] & hready) begin
			s_next.idx = haddr[9:2];
			s_next.bus = hwrite ? timer_unit_pkg::BUS_WRITE : timer_unit_pkg::BUS_READ;
			s_next.hready_o = hwrite;
		end else begin
			s_next.bus = timer_unit_pkg::BUS_IDLE;
			s_next.hready_o = 1'b1;
		end
		// Hardware flag sets win over a software clear in the same cycle
		s_next.timer_control[timer_unit_pkg::TF0_BIT] = s_next.timer_control[timer_unit_pkg::TF0_BIT] | set_tf0;
		s_next.timer_control[timer_unit_pkg::TF1_BIT] = s_next.timer_control[timer_unit_pkg::TF1_BIT] | set_tf1;
		s_next.t2stat[timer_unit_pkg::ST_OVF_BIT] = s_next.t2stat[timer_unit_pkg::ST_OVF_BIT] | ovf2;
		s_next.t2stat[timer_unit_pkg::ST_TRIG_BIT] = s_next.t2stat[timer_unit_pkg::ST_TRIG_BIT] | set_trig;
		s_next.t2stat[timer_unit_pkg::ST_MATCH_LSB +: 4] = s_next.t2stat[timer_unit_pkg::ST_MATCH_LSB +: 4] | match;
		for (int i = 0; i < 4; i++) begin
			s_next.cc_oe[i] = (s_next.ccen[2 * i +: 2] == timer_unit_pkg::CC_COMPARE);
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '{bus: timer_unit_pkg::BUS_IDLE, hready_o: 1'b1, timer_control: timer_unit_pkg::REG_RESET,
				timer_mode_select: timer_unit_pkg::REG_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = s_reg.hready_o;
	assign hrdata = s_reg.rdata;
	assign hresp = s_reg.hresp_o;
	assign capture_compare_pin_out = s_reg.cmp_out;
	assign capture_compare_pin_oe = s_reg.cc_oe;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	machine_cycle_period_a: assert property (tick |=> !tick ##11 tick) else $error("machine cycle not 12 clocks");
	count_rate_limit_a: assert property (fall[timer_unit_pkg::PIN_COUNT0] |->
		##12 !fall[timer_unit_pkg::PIN_COUNT0]) else $error("external count faster than allowed");
	full_count_step_a: assert property (ev0 && s_reg.timer_mode_select[1:0] == timer_unit_pkg::MODE_FULL && !wr_now
		|=> {s_reg.th0, s_reg.tl0} == $past({s_reg.th0, s_reg.tl0}) + 16'h0001)
		else $error("timer 0 mode 1 did not step");
	byte_reload_a: assert property (ev0 && s_reg.timer_mode_select[1:0] == timer_unit_pkg::MODE_RELOAD8 &&
		s_reg.tl0 == timer_unit_pkg::BYTE_MAX && !wr_now |=> s_reg.tl0 == $past(s_reg.th0))
		else $error("timer 0 byte reload wrong");
	split_hold_a: assert property (s_reg.timer_mode_select[5:4] == timer_unit_pkg::MODE_SPLIT && !wr_now
		|=> $stable({s_reg.th1, s_reg.tl1})) else $error("timer 1 moved in mode 3");
	gate_stop_a: assert property (s_reg.timer_mode_select[timer_unit_pkg::GATE_BIT] &&
		!s_reg.sync2[timer_unit_pkg::PIN_GATE_A] &&
		s_reg.timer_mode_select[1:0] == timer_unit_pkg::MODE_FULL && !wr_now |=> $stable({s_reg.th0, s_reg.tl0}))
		else $error("gated timer 0 counted");
	t2_reload_a: assert property (ovf2 && s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_EN_BIT] &&
		!s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_MODE_BIT] && !wr_now |=> s_reg.t2 == $past(s_reg.cc[0]))
		else $error("timer 2 overflow reload wrong");
	t2_overflow_flag_a: assert property (ovf2 |=> s_reg.t2stat[timer_unit_pkg::ST_OVF_BIT])
		else $error("timer 2 overflow flag not set");
	compare_clear_a: assert property (ovf2 && s_reg.ccen[7:6] == timer_unit_pkg::CC_COMPARE &&
		!s_reg.t2ctl[timer_unit_pkg::T2_COMPARE_MODE_BIT] && s_next.t2 != s_reg.cc[3] && !wr_now
		|=> !capture_compare_pin_out[3]) else $error("compare output not cleared");
	pin_capture_a: assert property (rise[timer_unit_pkg::PIN_CC_LSB + 2] &&
		s_reg.ccen[5:4] == timer_unit_pkg::CC_CAPTURE &&
		!s_reg.t2ctl[timer_unit_pkg::T2_CAPTURE_MODE_BIT] && !wr_now |=> s_reg.cc[2] == $past(s_reg.t2))
		else $error("pin capture missed");

	t0_overflow_c: cover property (ev0 && s_reg.timer_control[timer_unit_pkg::TF0_BIT] == 1'b0 ##1 s_reg.timer_control[timer_unit_pkg::TF0_BIT]);
	trigger_reload_c: cover property (fall[timer_unit_pkg::PIN_TRIG] && s_reg.t2ctl[timer_unit_pkg::T2_RELOAD_MODE_BIT]);
	compare_match_c: cover property (s_reg.ccen[7:6] == timer_unit_pkg::CC_COMPARE ##1 $rose(capture_compare_pin_out[3]));
	read_access_c: cover property (s_reg.bus == timer_unit_pkg::BUS_READ ##1 hreadyout);
endmodule : triple_timer_counter_unit
`default_nettype wire

// file: tb/far_side_pins.sv
`default_nettype none
module far_side_pins (
	input wire logic hclk,
	output logic count0,
	output logic count1,
	output logic gate_a,
	output logic gate_b,
	output logic t2_count,
	output logic trigger,
	output logic [3:0] cc_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels: count and trigger high so only a real falling edge counts
	initial begin
		count0 = 1'b1;
		count1 = 1'b1;
		gate_a = 1'b0;
		gate_b = 1'b0;
		t2_count = 1'b1;
		trigger = 1'b1;
		cc_in = 4'h0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge hclk);
	endtask : hold
	// Halves of 24 clocks keep the rate well under one edge per 24 clocks
	task automatic pulses(input int pin, input int n);
		repeat (2 * n) begin
			if (pin == 0) count0 <= ~count0;
			else if (pin == 1) count1 <= ~count1;
			else t2_count <= ~t2_count;
			hold(24);
		end
	endtask : pulses
	// Gate levels change only here, so each pin has one driver
	task automatic set_gates(input logic a, input logic b);
		gate_a <= a;
		gate_b <= b;
	endtask : set_gates
	// Held three machine cycles so the sampler cannot miss it
	task automatic cc_rise(input int ch);
		cc_in[ch] <= 1'b1;
		hold(36);
		cc_in[ch] <= 1'b0;
		hold(36);
	endtask : cc_rise
	task automatic trigger_fall();
		trigger <= 1'b0;
		hold(36);
		trigger <= 1'b1;
		hold(36);
	endtask : trigger_fall
endmodule : far_side_pins
`default_nettype wire

// file: tb/tb_triple_timer_counter_unit.sv
`default_nettype none
module tb_triple_timer_counter_unit;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic c0, c1, ga, gb, t2c, trg;
	logic [3:0] cci, cco, ccoe;
	logic [7:0] rd;
	int failures = 0, comparisons = 0, cycles = 0;
	always #10 hclk = ~hclk;
	far_side_pins far_u (.hclk(hclk), .count0(c0), .count1(c1), .gate_a(ga), .gate_b(gb), .t2_count(t2c),
		.trigger(trg), .cc_in(cci));
	triple_timer_counter_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .timer0_count_pin(c0), .timer1_count_pin(c1), .gate_input_a(ga), .gate_input_b(gb),
		.second_timer_count_pin(t2c), .reload_trigger_pin(trg), .capture_compare_pin_in(cci),
		.capture_compare_pin_out(cco), .capture_compare_pin_oe(ccoe));
	// Hang guard; the full run needs under two thousand cycles
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	task automatic close_out();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	// Ready and read data are taken at the rising edge that ends each phase
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask : wr
	task automatic check8(input logic [7:0] idx, input logic [7:0] exp, input string what);
		bus(idx, 1'b0, 8'h00);
		comparisons++;
		if (rd !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h want %h", $time, what, rd, exp);
		end
		check1(hresp, 1'b0, "bus response");
	endtask : check8
	task automatic check1(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask : check1
	task automatic t_reset_values();
		for (int i = 8'h88; i <= 8'h8d; i++) check8(8'(i), timer_unit_pkg::REG_RESET, "reset value");
		check8(8'h90, 8'h00, "unmapped read");
		$display("test reset_values done");
	endtask : t_reset_values
	task automatic t_mode1_overflow();
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h01);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'hfe);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_HIGH, 8'hff);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h10);
		far_u.hold(60);
		check8(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h30, "overflow flag");
		check8(timer_unit_pkg::IDX_TIMER0_COUNT_HIGH, 8'h00, "16-bit wrap");
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h00);
		$display("test mode1_overflow done");
	endtask : t_mode1_overflow
	task automatic t_mode0_prescale();
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h00);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'h1e);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_HIGH, 8'h00);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h10);
		far_u.hold(40);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h00);
		check8(timer_unit_pkg::IDX_TIMER0_COUNT_HIGH, 8'h01, "prescaler carry");
		$display("test mode0_prescale done");
	endtask : t_mode0_prescale
	task automatic t_counter_and_gate();
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h05);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'h00);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h10);
		far_u.pulses(0, 5);
		check8(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'h05, "edge count");
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h09);
		wr(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'h00);
		far_u.hold(60);
		check8(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 8'h00, "gate closed");
		far_u.set_gates(1'b1, 1'b0);
		far_u.hold(60);
		bus(timer_unit_pkg::IDX_TIMER0_COUNT_LOW, 1'b0, 8'h00);
		check1(rd != 8'h00, 1'b1, "gate open");
		far_u.set_gates(1'b0, 1'b0);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h00);
		$display("test counter_and_gate done");
	endtask : t_counter_and_gate
	task automatic t_timer1_modes();
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h30);
		wr(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'h55);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h40);
		far_u.hold(60);
		check8(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'h55, "mode 3 holds");
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'h20);
		wr(timer_unit_pkg::IDX_TIMER1_COUNT_HIGH, 8'hf0);
		wr(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'hfe);
		far_u.hold(60);
		check8(timer_unit_pkg::IDX_TIMER_CONTROL, 8'hc0, "reload overflow flag");
		bus(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 1'b0, 8'h00);
		check1(rd[7:4] === 4'hf && rd < 8'hfe, 1'b1, "auto reload");
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h00);
		$display("test timer1_modes done");
	endtask : t_timer1_modes
	task automatic t_timer2();
		wr(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 8'h34);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_HIGH_BYTE, 8'h12);
		wr(timer_unit_pkg::IDX_CC_ENABLE, 8'h14);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h20);
		wr(timer_unit_pkg::IDX_CC1_LOW, 8'haa);
		check8(timer_unit_pkg::IDX_CC1_LOW, 8'h34, "write capture low");
		check8(timer_unit_pkg::IDX_CC1_HIGH, 8'h12, "write capture high");
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h00);
		far_u.cc_rise(2);
		check8(timer_unit_pkg::IDX_CC2_LOW, 8'h34, "pin capture");
		wr(timer_unit_pkg::IDX_RELOAD_VALUE_LOW, 8'hcd);
		wr(timer_unit_pkg::IDX_RELOAD_VALUE_HIGH, 8'hab);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h18);
		far_u.trigger_fall();
		check8(timer_unit_pkg::IDX_SECOND_TIMER_HIGH_BYTE, 8'hab, "trigger reload");
		check8(timer_unit_pkg::IDX_SECOND_TIMER_STATUS, 8'h02, "trigger flag");
		$display("test timer2 done");
	endtask : t_timer2
	task automatic t_compare();
		wr(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 8'hfc);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_HIGH_BYTE, 8'hff);
		wr(timer_unit_pkg::IDX_RELOAD_VALUE_LOW, 8'h03);
		wr(timer_unit_pkg::IDX_RELOAD_VALUE_HIGH, 8'h00);
		wr(timer_unit_pkg::IDX_CC3_LOW, 8'h05);
		wr(timer_unit_pkg::IDX_CC3_HIGH, 8'h00);
		wr(timer_unit_pkg::IDX_CC_ENABLE, 8'h80);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_STATUS, 8'h00);
		check1(cco[3], 1'b0, "compare low before match");
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h11);
		far_u.hold(120);
		check1(cco[3], 1'b1, "compare high on match");
		check1(ccoe[3], 1'b1, "compare drives pin");
		check8(timer_unit_pkg::IDX_SECOND_TIMER_STATUS, 8'h21, "match and overflow flags");
		$display("test compare done");
	endtask : t_compare
	task automatic t_ext_counts();
		wr(timer_unit_pkg::IDX_TIMER_MODE_SELECT, 8'hd0);
		wr(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'h00);
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h40);
		far_u.set_gates(1'b0, 1'b1);
		far_u.pulses(1, 3);
		check8(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'h03, "timer 1 gated edges");
		far_u.set_gates(1'b0, 1'b0);
		far_u.pulses(1, 2);
		check8(timer_unit_pkg::IDX_TIMER1_COUNT_LOW, 8'h03, "timer 1 gate closed");
		wr(timer_unit_pkg::IDX_TIMER_CONTROL, 8'h00);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h06);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 8'h00);
		far_u.pulses(2, 4);
		check8(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 8'h04, "timer 2 edges");
		wr(timer_unit_pkg::IDX_SECOND_TIMER_CONTROL, 8'h05);
		wr(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 8'h00);
		far_u.hold(240);
		bus(timer_unit_pkg::IDX_SECOND_TIMER_LOW_BYTE, 1'b0, 8'h00);
		check1(rd >= 8'h09 && rd <= 8'h0b, 1'b1, "halved timer rate");
		$display("test ext_counts done");
	endtask : t_ext_counts
	// Main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset_values();
		t_mode1_overflow();
		t_mode0_prescale();
		t_counter_and_gate();
		t_timer1_modes();
		t_timer2();
		t_compare();
		t_ext_counts();
		close_out();
	end
endmodule : tb_triple_timer_counter_unit
`default_nettype wire
